// [rtl/mps_pkg.sv]
// Shared constants and types for the metering power-up sequencer
package mps_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_FLAGS_FIRST  = 16'hE502;
  localparam logic [15:0] ADDR_FLAGS_SECOND = 16'hE503;
  localparam logic [15:0] ADDR_MASK_FIRST   = 16'hE50A;
  localparam logic [15:0] ADDR_MASK_SECOND  = 16'hE50B;
  localparam logic [31:0] FLAGS_RESET       = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET        = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED     = 32'h0000_0000;
  localparam int          RESET_DONE_BIT    = 15;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ   = 125000;
  localparam int HOLD_TIME_MS   = 32;
  localparam int CLK_DELAY_US   = 20;
  localparam int HOLD_CYCLES    = HOLD_TIME_MS * CLK_FREQ_KHZ;
  localparam int DELAY_CYCLES   = (CLK_DELAY_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int FE_CLK_DIV     = 4;
  localparam int TAP_FALLS      = 8;
  localparam int SELECT_FALLS   = 3;
  localparam int TIMER_W        = 23;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INACTIVE,
    ST_HOLD,
    ST_CLK_WAIT,
    ST_TOGGLE,
    ST_DONE
  } mps_state_t;

  // Lines toward the isolated front-end devices
  typedef struct packed {
    logic       frontendClockOutput;
    logic       resetEnableN;
    logic [3:0] tapLines;   // neutral, C, B, A from msb down
  } mps_frontend_t;

endpackage

// [rtl/mps_sequencer.sv]
// Power-up sequencer, front-end reset generator and reset-done status
`timescale 1ns/1ps
// Behaviour
// - After supply-good asserts, stay inactive a further 32 ms.
// - After the hold, drive a continuous divided clock to the front-ends.
// - 20 us after the clock starts, drive reset-enable low.
// - While reset-enable is low, all four tap lines fall exactly eight times.
// - After eight falls, raise reset-enable and all tap lines.
// - When complete, drive the second interrupt low and set flag bit 15.
// - Reset-done flag stays 0 during the sequence, set only at completion.
// - At the end of power-up the two-wire port is the host interface.
// - On power-up every software register takes its default value.
// - Three slave-select falls switch the host interface to SPI.
// - Writing 1 to bit 15 clears reset-done and releases the interrupt.
// - Reset-done interrupt is unmaskable; the mask cannot hide it.
// - Status flags clear on a written 1; a written 0 leaves them.
// - Supply-good loss returns to inactive and stops measurement.
module mps_sequencer #(
  parameter int HOLD_CYCLES  = mps_pkg::HOLD_CYCLES,
  parameter int DELAY_CYCLES = mps_pkg::DELAY_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   supplyGood,
  input  wire logic                   slaveSelectLine,
  input  wire logic [31:0]            eventFlagsFirst,
  input  wire logic [31:0]            eventFlagsSecond,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  input  wire logic [15:0]            regAddr,
  input  wire logic [31:0]            regWrData,
  output logic      [31:0]            regRdData,
  output logic                        regRdValid,
  output mps_pkg::mps_frontend_t      frontend,
  output logic                        firstInterruptN,
  output logic                        secondInterruptN,
  output logic                        hostPortSpi,
  output logic                        measureEnable
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic       rstMeta_r;
  logic       rstSync_n;
  logic [1:0] pgSync_r;
  logic [1:0] ssSync_r;
  logic       ssPrev_r;

  // Asynchronous assert, synchronous release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // Two stages per pin; only the second stage, bit 1, is read by logic
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pgSync_r <= 2'b00;
      ssSync_r <= 2'b11;
      ssPrev_r <= 1'b1;
    end else begin
      pgSync_r <= {pgSync_r[0], supplyGood};
      ssSync_r <= {ssSync_r[0], slaveSelectLine};
      ssPrev_r <= ssSync_r[1];
    end
  end

  logic powerGood;
  logic ssFall;
  assign powerGood = pgSync_r[1];
  assign ssFall    = ssPrev_r & ~ssSync_r[1];

  // ----------------------------------------------------------------
  // Sequencer state machine
  // ----------------------------------------------------------------
  localparam int DIV_W = $clog2(mps_pkg::FE_CLK_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(mps_pkg::FE_CLK_DIV - 1);
  localparam logic [3:0] FALL_LAST = 4'(mps_pkg::TAP_FALLS - 1);
  localparam logic [mps_pkg::TIMER_W-1:0] HOLD_LAST =
    mps_pkg::TIMER_W'(HOLD_CYCLES - 1);
  localparam logic [mps_pkg::TIMER_W-1:0] DELAY_LAST =
    mps_pkg::TIMER_W'(DELAY_CYCLES - 1);

  mps_pkg::mps_state_t          state_r;
  mps_pkg::mps_state_t          state_nxt;
  logic [mps_pkg::TIMER_W-1:0]  timer_r;
  logic [DIV_W-1:0]             divPhase_r;
  logic [3:0]                   fallCnt_r;
  logic                         clockRunning;
  logic                         periodEnd;
  logic                         seqDone;

  assign clockRunning = (state_r == mps_pkg::ST_CLK_WAIT) ||
                        (state_r == mps_pkg::ST_TOGGLE) ||
                        (state_r == mps_pkg::ST_DONE);
  assign periodEnd    = (divPhase_r == DIV_LAST);
  assign seqDone      = (state_r == mps_pkg::ST_TOGGLE) && periodEnd &&
                        (fallCnt_r == FALL_LAST);

  // Next state; supply loss wins from every state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mps_pkg::ST_INACTIVE: begin
        if (powerGood) begin
          state_nxt = mps_pkg::ST_HOLD;
        end
      end
      mps_pkg::ST_HOLD: begin
        if (timer_r == HOLD_LAST) begin
          state_nxt = mps_pkg::ST_CLK_WAIT;
        end
      end
      mps_pkg::ST_CLK_WAIT: begin
        // Align to a period boundary so every burst has whole periods
        if (timer_r >= DELAY_LAST && periodEnd) begin
          state_nxt = mps_pkg::ST_TOGGLE;
        end
      end
      mps_pkg::ST_TOGGLE: begin
        if (seqDone) begin
          state_nxt = mps_pkg::ST_DONE;
        end
      end
      mps_pkg::ST_DONE: begin
        state_nxt = mps_pkg::ST_DONE;
      end
      default: begin
        state_nxt = mps_pkg::ST_INACTIVE;
      end
    endcase
    if (!powerGood) begin
      state_nxt = mps_pkg::ST_INACTIVE;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r <= mps_pkg::ST_INACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Cycle timer for the hold and the clock-to-reset delay
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      timer_r <= '0;
    end else if (state_nxt != state_r) begin
      timer_r <= '0;
    end else if (timer_r != {mps_pkg::TIMER_W{1'b1}}) begin
      timer_r <= timer_r + 1'b1;
    end
  end

  // Divider phase; stopped while the front-end clock is parked high
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      divPhase_r <= '0;
    end else if (!clockRunning) begin
      divPhase_r <= '0;
    end else begin
      divPhase_r <= divPhase_r + 1'b1;
    end
  end

  // Counts completed tap periods within the burst
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      fallCnt_r <= '0;
    end else if (state_r != mps_pkg::ST_TOGGLE) begin
      fallCnt_r <= '0;
    end else if (periodEnd) begin
      fallCnt_r <= fallCnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Front-end lines
  // ----------------------------------------------------------------
  logic       feClk_r;
  logic       resetEnN_r;
  logic [3:0] taps_r;

  // Clock parks high when stopped, runs at clk/4 otherwise
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      feClk_r <= 1'b1;
    end else begin
      feClk_r <= clockRunning ? ~divPhase_r[DIV_W-1] : 1'b1;
    end
  end

  // Reset-enable low for exactly the burst window
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      resetEnN_r <= 1'b1;
    end else begin
      resetEnN_r <= (state_r != mps_pkg::ST_TOGGLE);
    end
  end

  // Each tap line low in the second half of every burst period
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gTap
      always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
          taps_r[g] <= 1'b1;
        end else begin
          taps_r[g] <= ~((state_r == mps_pkg::ST_TOGGLE) &&
                         divPhase_r[DIV_W-1]);
        end
      end
    end
  endgenerate

  assign frontend.frontendClockOutput = feClk_r;
  assign frontend.resetEnableN        = resetEnN_r;
  assign frontend.tapLines            = taps_r;

  // ----------------------------------------------------------------
  // Host port selection
  // ----------------------------------------------------------------
  logic [1:0] ssCnt_r;
  logic       spiSel_r;

  // Port choice only counts once the chipset is up; reverts on supply loss
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ssCnt_r  <= '0;
      spiSel_r <= 1'b0;
    end else if (state_r != mps_pkg::ST_DONE || !powerGood) begin
      ssCnt_r  <= '0;
      spiSel_r <= 1'b0;
    end else if (ssFall && !spiSel_r) begin
      if (ssCnt_r == 2'(mps_pkg::SELECT_FALLS - 1)) begin
        spiSel_r <= 1'b1;
      end
      ssCnt_r <= ssCnt_r + 1'b1;
    end
  end

  assign hostPortSpi   = spiSel_r;
  assign measureEnable = (state_r == mps_pkg::ST_DONE);

  // ----------------------------------------------------------------
  // Status and mask registers
  // ----------------------------------------------------------------
  logic [31:0] flagsFirst_r;
  logic [31:0] flagsSecond_r;
  logic [31:0] maskFirst_r;
  logic [31:0] maskSecond_r;
  logic        wrFlagsFirst;
  logic        wrFlagsSecond;
  logic [31:0] setSecond;
  logic [31:0] clrFirst;
  logic [31:0] clrSecond;

  assign wrFlagsFirst  = regWrite && (regAddr == mps_pkg::ADDR_FLAGS_FIRST);
  assign wrFlagsSecond = regWrite && (regAddr == mps_pkg::ADDR_FLAGS_SECOND);
  assign clrFirst      = wrFlagsFirst ? regWrData : '0;
  assign clrSecond     = wrFlagsSecond ? regWrData : '0;

  // Event sources are ignored until the chipset is up
  always_comb begin
    setSecond = measureEnable ? eventFlagsSecond : '0;
    setSecond[mps_pkg::RESET_DONE_BIT] = seqDone;
  end

  // Set beats clear in the same cycle so no event is lost
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      flagsFirst_r  <= mps_pkg::FLAGS_RESET;
      flagsSecond_r <= mps_pkg::FLAGS_RESET;
    end else if (state_r != mps_pkg::ST_DONE && !seqDone) begin
      flagsFirst_r  <= mps_pkg::FLAGS_RESET;
      flagsSecond_r <= mps_pkg::FLAGS_RESET;
    end else begin
      flagsFirst_r  <= (flagsFirst_r & ~clrFirst) |
                       (measureEnable ? eventFlagsFirst : '0);
      flagsSecond_r <= (flagsSecond_r & ~clrSecond) | setSecond;
    end
  end

  // Masks are plain read/write and take defaults whenever power is lost
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      maskFirst_r  <= mps_pkg::MASK_RESET;
      maskSecond_r <= mps_pkg::MASK_RESET;
    end else if (state_r == mps_pkg::ST_INACTIVE) begin
      maskFirst_r  <= mps_pkg::MASK_RESET;
      maskSecond_r <= mps_pkg::MASK_RESET;
    end else if (regWrite && regAddr == mps_pkg::ADDR_MASK_FIRST) begin
      maskFirst_r <= regWrData;
    end else if (regWrite && regAddr == mps_pkg::ADDR_MASK_SECOND) begin
      maskSecond_r <= regWrData;
    end
  end

  // Reset-done bypasses the mask; its mask bit has no effect
  logic [31:0] maskSecondEff;
  always_comb begin
    maskSecondEff = maskSecond_r;
    maskSecondEff[mps_pkg::RESET_DONE_BIT] = 1'b1;
  end

  assign firstInterruptN  = ~|(flagsFirst_r & maskFirst_r);
  assign secondInterruptN = ~|(flagsSecond_r & maskSecondEff);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regRdData  <= mps_pkg::READ_UNMAPPED;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        case (regAddr)
          mps_pkg::ADDR_FLAGS_FIRST:  regRdData <= flagsFirst_r;
          mps_pkg::ADDR_FLAGS_SECOND: regRdData <= flagsSecond_r;
          mps_pkg::ADDR_MASK_FIRST:   regRdData <= maskFirst_r;
          mps_pkg::ADDR_MASK_SECOND:  regRdData <= maskSecond_r;
          default:                    regRdData <= mps_pkg::READ_UNMAPPED;
        endcase
      end
    end
  end

endmodule

// [sim/mps_sequencer_chk.sv]
// Port-level assertions for the power-up sequencer
`timescale 1ns/1ps
module mps_sequencer_chk #(
  parameter int HOLD_CYCLES  = 50,
  parameter int DELAY_CYCLES = 10
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   supplyGood,
  input wire logic                   slaveSelectLine,
  input wire logic [31:0]            eventFlagsFirst,
  input wire logic [31:0]            eventFlagsSecond,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic [15:0]            regAddr,
  input wire logic [31:0]            regWrData,
  input wire logic [31:0]            regRdData,
  input wire logic                   regRdValid,
  input wire mps_pkg::mps_frontend_t frontend,
  input wire logic                   firstInterruptN,
  input wire logic                   secondInterruptN,
  input wire logic                   hostPortSpi,
  input wire logic                   measureEnable
);
  // ----------------------------------------------------------------
  // Shorthands
  // ----------------------------------------------------------------
  logic [3:0] taps;
  logic       fco;
  logic       rstEnN;
  logic       wrSecond;
  // Short names keep each property on few lines
  assign taps     = frontend.tapLines;
  assign fco      = frontend.frontendClockOutput;
  assign rstEnN   = frontend.resetEnableN;
  assign wrSecond = regWrite && regAddr == mps_pkg::ADDR_FLAGS_SECOND;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_taps_in_reset: assert property (taps != 4'hF |-> !rstEnN)
    else $error("tap line low while reset enable high");
  a_taps_all_equal: assert property (taps == 4'h0 || taps == 4'hF)
    else $error("tap lines disagree");
  a_first_tap_fall: assert property ($fell(rstEnN) |-> ##2 taps == 4'h0)
    else $error("first tap fall late or early");
  a_done_irq_low: assert property ($rose(measureEnable) |-> !secondInterruptN)
    else $error("no interrupt at completion");
  a_done_lines_up: assert property ($rose(measureEnable) |=> rstEnN && taps == 4'hF)
    else $error("front-end reset not ended");
  a_irq_unmaskable: assert property (!secondInterruptN && measureEnable
      && !(wrSecond && regWrData[15]) |=> !secondInterruptN || !measureEnable)
    else $error("interrupt released without clear");
  a_irq_clear_all: assert property (wrSecond && regWrData == 32'hFFFF_FFFF
      && eventFlagsSecond == 32'h0000_0000 && measureEnable |=> secondInterruptN)
    else $error("interrupt not released by clear");
  a_flag_zero_seq: assert property (regRead && regAddr == mps_pkg::ADDR_FLAGS_SECOND
      && !measureEnable |=> regRdData[15] == 1'b0)
    else $error("reset-done flag set during sequence");
  a_unmapped_read: assert property (regRead && regAddr == 16'h0000
      |=> regRdValid && regRdData == mps_pkg::READ_UNMAPPED)
    else $error("unmapped read wrong");
  a_spi_after_done: assert property (!measureEnable |-> !hostPortSpi)
    else $error("spi selected outside done");
  a_fe_clk_period: assert property ($fell(fco) && supplyGood |=> !fco ##1 fco)
    else $error("front-end clock not clk over four");
endmodule

// [sim/mps_fe_model.sv]
// Behavioural model of the isolated front-end devices
`timescale 1ns/1ps
module mps_fe_model (
  input  wire mps_pkg::mps_frontend_t frontend,
  input  wire logic                   clr,
  output logic [7:0]                  tapFalls = 8'h00,
  output logic [15:0]                 clkRises = 16'h0000
);
  logic tapA;
  logic feClk;
  assign tapA  = frontend.tapLines[0];
  assign feClk = frontend.frontendClockOutput;

  // A front-end only counts falls while its reset input is held low
  always @(negedge tapA or posedge clr) begin
    if (clr) tapFalls = 8'h00;
    else if (!frontend.resetEnableN) tapFalls = tapFalls + 8'h01;
  end

  // Clock edges seen by the front-end, proof that it is running
  always @(posedge feClk or posedge clr) begin
    if (clr) clkRises = 16'h0000;
    else clkRises = clkRises + 16'h0001;
  end
endmodule

// [sim/mps_sequencer_tb.sv]
// Self-checking bench for the power-up sequencer
`timescale 1ns/1ps
module mps_sequencer_tb;
  localparam int HP = 50;
  localparam int DP = 10;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   supplyGood = 1'b0;
  logic                   slaveSelectLine = 1'b1;
  logic [31:0]            eventFlagsFirst = 32'h0000_0000;
  logic [31:0]            eventFlagsSecond = 32'h0000_0000;
  logic                   regWrite = 1'b0;
  logic                   regRead = 1'b0;
  logic [15:0]            regAddr = 16'h0000;
  logic [31:0]            regWrData = 32'h0000_0000;
  logic [31:0]            regRdData;
  logic                   regRdValid;
  logic                   firstInterruptN;
  logic                   secondInterruptN;
  logic                   hostPortSpi;
  logic                   measureEnable;
  mps_pkg::mps_frontend_t frontend;
  logic                   clr = 1'b0;
  logic [7:0]             tapFalls;
  logic [15:0]            clkRises;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  int                     cyc = 0;

  mps_sequencer #(.HOLD_CYCLES(HP), .DELAY_CYCLES(DP)) dut (
    .clk(clk), .rst_n(rst_n), .supplyGood(supplyGood), .slaveSelectLine(slaveSelectLine),
    .eventFlagsFirst(eventFlagsFirst), .eventFlagsSecond(eventFlagsSecond),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .frontend(frontend),
    .firstInterruptN(firstInterruptN), .secondInterruptN(secondInterruptN),
    .hostPortSpi(hostPortSpi), .measureEnable(measureEnable));
  mps_fe_model fe (.frontend(frontend), .clr(clr), .tapFalls(tapFalls), .clkRises(clkRises));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #4 clk = ~clk;

  // Ceiling well above two full power-ups at the short sim counts
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask

  task automatic chkb(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    tick(1);
    regWrite = 1'b0;
    tick(1);
  endtask

  // Read lands one edge after the strobe; extra tick spaces strobes apart
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    regAddr = a;
    regRead = 1'b1;
    tick(1);
    regRead = 1'b0;
    chkb(regRdValid, 1'b1);
    chk(regRdData, e);
    tick(1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic powerup();
    int c;
    int d;
    c = 0;
    d = 0;
    clr = 1'b1;
    supplyGood = 1'b1;
    tick(1);
    clr = 1'b0;
    while (frontend.frontendClockOutput && c < 200) begin
      tick(1);
      c++;
    end
    chkb(c >= HP && c <= HP + 5, 1'b1);
    while (frontend.resetEnableN && d < 100) begin
      tick(1);
      d++;
    end
    chkb(d >= DP && d <= DP + 8, 1'b1);
    chkb(clkRises != 16'h0000, 1'b1);
    rdc(mps_pkg::ADDR_FLAGS_SECOND, 32'h0000_0000);
    c = 0;
    // After one read mid-sequence, host waits for the interrupt
    while (secondInterruptN && c < 100) begin
      tick(1);
      c++;
    end
    chkb(measureEnable, 1'b1);
    chk({24'h0, tapFalls}, 32'h0000_0008);
    tick(1);
    chk({26'h0, frontend}, 32'h0000_003F);
    chkb(secondInterruptN, 1'b0);
    chkb(hostPortSpi, 1'b0);
  endtask

  task automatic regs();
    rdc(mps_pkg::ADDR_FLAGS_SECOND, 32'h0000_8000);
    rdc(mps_pkg::ADDR_FLAGS_FIRST, mps_pkg::FLAGS_RESET);
    rdc(mps_pkg::ADDR_MASK_SECOND, mps_pkg::MASK_RESET);
    rdc(16'h0000, mps_pkg::READ_UNMAPPED);
    wr(mps_pkg::ADDR_MASK_SECOND, 32'h0000_0000);
    chkb(secondInterruptN, 1'b0);
    wr(mps_pkg::ADDR_FLAGS_SECOND, 32'hFFFF_7FFF);
    chkb(secondInterruptN, 1'b0);
    wr(mps_pkg::ADDR_FLAGS_SECOND, 32'h0000_8000);
    chkb(secondInterruptN, 1'b1);
    rdc(mps_pkg::ADDR_FLAGS_SECOND, 32'h0000_0000);
  endtask

  task automatic events();
    eventFlagsFirst = 32'h0000_0008;
    eventFlagsSecond = 32'h0000_0010;
    tick(1);
    eventFlagsFirst = 32'h0000_0000;
    eventFlagsSecond = 32'h0000_0000;
    chkb(firstInterruptN, 1'b1);
    chkb(secondInterruptN, 1'b1);
    rdc(mps_pkg::ADDR_FLAGS_FIRST, 32'h0000_0008);
    rdc(mps_pkg::ADDR_FLAGS_SECOND, 32'h0000_0010);
    wr(mps_pkg::ADDR_MASK_FIRST, 32'h0000_0008);
    chkb(firstInterruptN, 1'b0);
    wr(mps_pkg::ADDR_FLAGS_FIRST, 32'hFFFF_FFFF);
    chkb(firstInterruptN, 1'b1);
    wr(mps_pkg::ADDR_FLAGS_SECOND, 32'hFFFF_FFFF);
    rdc(mps_pkg::ADDR_FLAGS_FIRST, 32'h0000_0000);
    rdc(mps_pkg::ADDR_FLAGS_SECOND, 32'h0000_0000);
  endtask

  task automatic spi();
    repeat (3) begin
      chkb(hostPortSpi, 1'b0);
      slaveSelectLine = 1'b0;
      tick(4);
      slaveSelectLine = 1'b1;
      tick(4);
    end
    chkb(hostPortSpi, 1'b1);
  endtask

  task automatic loss();
    supplyGood = 1'b0;
    tick(5);
    chkb(measureEnable, 1'b0);
    chk({26'h0, frontend}, 32'h0000_003F);
    chkb(hostPortSpi, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(4);
    powerup();
    regs();
    events();
    spi();
    loss();
    powerup();
    rdc(mps_pkg::ADDR_MASK_FIRST, mps_pkg::MASK_RESET);
    finish_test();
  end
endmodule

bind mps_sequencer mps_sequencer_chk #(.HOLD_CYCLES(HOLD_CYCLES), .DELAY_CYCLES(DELAY_CYCLES))
  u_chk (.clk(clk), .rst_n(rst_n), .supplyGood(supplyGood), .slaveSelectLine(slaveSelectLine),
    .eventFlagsFirst(eventFlagsFirst), .eventFlagsSecond(eventFlagsSecond),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .frontend(frontend),
    .firstInterruptN(firstInterruptN), .secondInterruptN(secondInterruptN),
    .hostPortSpi(hostPortSpi), .measureEnable(measureEnable));
